// *** rtl/lpsdc_pkg.sv ***
// Package of command codes, operating states and timing counts for the command/state block.
package lpsdc_pkg;

    // ****************************************************************
    // Clock and timing.
    // ****************************************************************
    localparam int CLK_PERIOD_PS      = 8000;    // Clock period in picoseconds.
    localparam int REFRESH_CYCLE_PS   = 72000;   // Refresh busy time in picoseconds.
    localparam int REFRESH_CYCLES     = (REFRESH_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PRECHARGE_PS       = 24000;   // Bank precharge time in picoseconds.
    localparam int PRECHARGE_CYCLES   = (PRECHARGE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ROW_ADDR_W         = 12;      // Width of the internal refresh row counter.
    localparam int NUM_BANKS          = 4;       // Number of banks.

    // ****************************************************************
    // Decoded commands.
    // ****************************************************************
    typedef enum logic [3:0] {
        LPSDC_CMD_DESELECT,
        LPSDC_CMD_NOP,
        LPSDC_CMD_ACTIVE,
        LPSDC_CMD_READ,
        LPSDC_CMD_WRITE,
        LPSDC_CMD_PRECHARGE,
        LPSDC_CMD_BURST_STOP,
        LPSDC_CMD_REFRESH,
        LPSDC_CMD_MODE_SET
    } lpsdc_cmd_e;

    // Device operating states.
    typedef enum logic [2:0] {
        LPSDC_ST_IDLE,
        LPSDC_ST_REFRESHING,
        LPSDC_ST_SELF_REFRESH,
        LPSDC_ST_PRE_PD,
        LPSDC_ST_ACT_PD,
        LPSDC_ST_DEEP_SLEEP
    } lpsdc_state_e;

    // Command pins as sampled on a rising clock edge.
    typedef struct packed {
        logic       clk_en;     // Clock enable.
        logic       cs_n;       // Chip select, active low.
        logic       ras_n;      // Row strobe, active low.
        logic       cas_n;      // Column strobe, active low.
        logic       we_n;       // Write enable, active low.
        logic [1:0] bank;       // Bank address.
        logic       all_banks;  // Precharge-all address bit.
    } lpsdc_pins_s;

endpackage

// *** rtl/lpsdc_core.sv ***
// Command decoder and operating-state controller of a low-power DDR memory.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - CS RAS CAS low, CKE WE high: refresh.
// - Refresh rows come from internal counter.
// - Refresh completion leaves all banks idle.
// - Refresh with CKE low enters self refresh.
// - Self refresh held by CKE low only.
// - Internal clock gated during self refresh.
// - CKE low enters precharge or active power-down.
// - Power-down ignores all inputs but clock enable and the exit NOP.
// - CKE high with NOP exits power-down.
// - CKE fall with refresh or stop: special modes.
// - CKE low twice holds the low-power state.
// - Deselect and NOP let operations continue.
// - Strobe patterns decode to the bank commands.
// - Precharge or read truncates a write burst.
// - Other-bank command legality by bank state.
module lpsdc_core #(
    parameter int REFRESH_CYCLES = lpsdc_pkg::REFRESH_CYCLES,  // Refresh busy cycles.
    parameter int ROW_ADDR_W     = lpsdc_pkg::ROW_ADDR_W       // Refresh counter width.
) (
    input  wire logic                     i_mclk,            // System clock.
    input  wire logic                     i_rst,             // Synchronous reset, active high.
    input  wire lpsdc_pkg::lpsdc_pins_s   i_pins,            // Command pins from the outside.
    output logic [3:0]                    o_cmd,             // Registered decoded command.
    output logic                          o_cmd_valid,       // Command accepted this edge.
    output logic [2:0]                    o_state,           // Registered operating state.
    output logic [lpsdc_pkg::NUM_BANKS-1:0] o_bank_open,     // Banks with an open row.
    output logic [lpsdc_pkg::NUM_BANKS-1:0] o_bank_writing,  // Banks in a write burst.
    output logic                          o_write_truncated, // Pulse: write burst truncated.
    output logic [ROW_ADDR_W-1:0]         o_refresh_row,     // Internal refresh row.
    output logic                          o_refresh_busy,    // Refresh in progress.
    output logic                          o_core_clk_en,     // Internal clock gate enable.
    output logic                          o_buffers_en,      // Input/output buffers enabled.
    output logic                          o_illegal          // Pulse: illegal command seen.
);

    // ****************************************************************
    // Parameter checks.
    // ****************************************************************
    if (REFRESH_CYCLES < 1 || REFRESH_CYCLES > 255) begin : g_bad_refresh
        $error("REFRESH_CYCLES must lie between 1 and 255.");
    end
    if (ROW_ADDR_W < 1) begin : g_bad_row
        $error("ROW_ADDR_W must be at least 1.");
    end

    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    lpsdc_pkg::lpsdc_pins_s pins_meta;  // First stage, read only by the second.
    lpsdc_pkg::lpsdc_pins_s pins;       // Second stage, used by all logic.
    logic                   cke_prev;   // Clock enable at the previous edge.

    // Two flip-flops bring the pins into the clock domain.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pins_meta <= '0;
            pins      <= '0;
            cke_prev  <= 1'b0;
        end else begin
            pins_meta <= i_pins;
            pins      <= pins_meta;
            cke_prev  <= pins.clk_en;
        end
    end

    // ****************************************************************
    // Command decode.
    // ****************************************************************
    logic [2:0]           strobes;                   // Row, column and write strobes.
    lpsdc_pkg::lpsdc_cmd_e cmd;                      // Decoded command.
    assign strobes = {pins.ras_n, pins.cas_n, pins.we_n};
    // Deselect, NOP and the bank commands follow the strobe patterns.
    assign cmd = pins.cs_n           ? lpsdc_pkg::LPSDC_CMD_DESELECT :
                 (strobes == 3'h7)   ? lpsdc_pkg::LPSDC_CMD_NOP :
                 (strobes == 3'h3)   ? lpsdc_pkg::LPSDC_CMD_ACTIVE :
                 (strobes == 3'h5)   ? lpsdc_pkg::LPSDC_CMD_READ :
                 (strobes == 3'h4)   ? lpsdc_pkg::LPSDC_CMD_WRITE :
                 (strobes == 3'h2)   ? lpsdc_pkg::LPSDC_CMD_PRECHARGE :
                 (strobes == 3'h6)   ? lpsdc_pkg::LPSDC_CMD_BURST_STOP :
                 (strobes == 3'h1)   ? lpsdc_pkg::LPSDC_CMD_REFRESH :
                                       lpsdc_pkg::LPSDC_CMD_MODE_SET;

    // ****************************************************************
    // Operating state machine.
    // ****************************************************************
    lpsdc_pkg::lpsdc_state_e state;        // Current operating state.
    lpsdc_pkg::lpsdc_state_e next_state;   // Next operating state.
    logic [7:0]              ref_count;    // Refresh cycles remaining.
    logic [7:0]              next_ref_count;
    logic                    all_idle;     // No bank open.
    logic                    nop_like;     // Deselect or NOP.
    logic                    cke_high;     // Clock enable high on both edges.
    logic                    cke_fall;     // Clock enable falling this edge.
    logic                    cke_rise;     // Clock enable rising this edge.
    logic                    bank_cmd;     // Bank commands are decoded this edge.
    logic                    refresh_go;   // Auto refresh accepted.
    logic [lpsdc_pkg::NUM_BANKS-1:0] bank_open;     // Open row per bank.
    logic [lpsdc_pkg::NUM_BANKS-1:0] bank_writing;  // Write burst per bank.

    assign all_idle   = (bank_open == '0);
    assign nop_like   = (cmd == lpsdc_pkg::LPSDC_CMD_DESELECT) ||
                        (cmd == lpsdc_pkg::LPSDC_CMD_NOP);
    assign cke_high   = cke_prev & pins.clk_en;
    assign cke_fall   = cke_prev & ~pins.clk_en;
    assign cke_rise   = ~cke_prev & pins.clk_en;
    assign bank_cmd   = cke_high && (state == lpsdc_pkg::LPSDC_ST_IDLE);
    assign refresh_go = bank_cmd && all_idle &&
                        (cmd == lpsdc_pkg::LPSDC_CMD_REFRESH);

    // Next state from the clock-enable truth table.
    always_comb begin
        next_state     = state;
        next_ref_count = ref_count;
        case (state)
            lpsdc_pkg::LPSDC_ST_IDLE: begin
                if (refresh_go) begin
                    next_state     = lpsdc_pkg::LPSDC_ST_REFRESHING;
                    next_ref_count = 8'(REFRESH_CYCLES);
                end else if (cke_fall && all_idle &&
                             cmd == lpsdc_pkg::LPSDC_CMD_REFRESH) begin
                    next_state = lpsdc_pkg::LPSDC_ST_SELF_REFRESH;
                end else if (cke_fall && all_idle &&
                             cmd == lpsdc_pkg::LPSDC_CMD_BURST_STOP) begin
                    next_state = lpsdc_pkg::LPSDC_ST_DEEP_SLEEP;
                end else if (cke_fall && nop_like) begin
                    // Precharge or active power-down by bank status.
                    next_state = all_idle ? lpsdc_pkg::LPSDC_ST_PRE_PD :
                                            lpsdc_pkg::LPSDC_ST_ACT_PD;
                end
            end
            lpsdc_pkg::LPSDC_ST_REFRESHING: begin
                // Inputs other than NOP are outside the contract here.
                if (ref_count <= 8'h01) begin
                    next_state = lpsdc_pkg::LPSDC_ST_IDLE;
                end
                next_ref_count = ref_count - 8'h01;
            end
            lpsdc_pkg::LPSDC_ST_SELF_REFRESH,
            lpsdc_pkg::LPSDC_ST_DEEP_SLEEP: begin
                // Only clock enable is watched; low holds the state.
                if (cke_rise) begin
                    next_state = lpsdc_pkg::LPSDC_ST_IDLE;
                end
            end
            lpsdc_pkg::LPSDC_ST_PRE_PD,
            lpsdc_pkg::LPSDC_ST_ACT_PD: begin
                // Exit needs clock enable high with a NOP or deselect.
                if (cke_rise && nop_like) begin
                    next_state = lpsdc_pkg::LPSDC_ST_IDLE;
                end
            end
            default: begin
                next_state = lpsdc_pkg::LPSDC_ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state     <= lpsdc_pkg::LPSDC_ST_IDLE;
            ref_count <= 8'h00;
        end else begin
            state     <= next_state;
            ref_count <= next_ref_count;
        end
    end

    // ****************************************************************
    // Per-bank tracking.
    // ****************************************************************
    logic [lpsdc_pkg::NUM_BANKS-1:0] trunc_vec;   // Truncation per bank.
    logic [lpsdc_pkg::NUM_BANKS-1:0] illegal_vec; // Illegal command per bank.

    for (genvar b = 0; b < lpsdc_pkg::NUM_BANKS; b++) begin : g_bank
        logic hit;         // Command addresses this bank.
        logic pre_hit;     // Precharge reaches this bank.
        logic next_open;   // Next open-row flag.
        logic next_write;  // Next write-burst flag.
        assign hit      = bank_cmd && (pins.bank == 2'(b));
        assign pre_hit  = bank_cmd && (cmd == lpsdc_pkg::LPSDC_CMD_PRECHARGE) &&
                          (pins.all_banks || pins.bank == 2'(b));
        // Precharge or read to a writing bank truncates its burst.
        assign trunc_vec[b] = bank_writing[b] && (pre_hit ||
                              (hit && cmd == lpsdc_pkg::LPSDC_CMD_READ));
        // Column commands need an open row; activate needs an idle bank.
        assign illegal_vec[b] = hit && (
            ((cmd == lpsdc_pkg::LPSDC_CMD_READ || cmd == lpsdc_pkg::LPSDC_CMD_WRITE) &&
             !bank_open[b]) ||
            (cmd == lpsdc_pkg::LPSDC_CMD_ACTIVE && bank_open[b]));
        assign next_open  = pre_hit ? 1'b0 :
                            (hit && cmd == lpsdc_pkg::LPSDC_CMD_ACTIVE) ? 1'b1 :
                            bank_open[b];
        assign next_write = (pre_hit || !next_open) ? 1'b0 :
                            (hit && cmd == lpsdc_pkg::LPSDC_CMD_WRITE) ? 1'b1 :
                            (hit && cmd == lpsdc_pkg::LPSDC_CMD_READ) ? 1'b0 :
                            bank_writing[b];
        // Bank flags; other banks keep their state on any command except precharge all.
        always_ff @(posedge i_mclk) begin
            if (i_rst) begin
                bank_open[b]    <= 1'b0;
                bank_writing[b] <= 1'b0;
            end else begin
                bank_open[b]    <= next_open;
                bank_writing[b] <= next_write;
            end
        end
    end

    // ****************************************************************
    // Refresh row counter and outputs.
    // ****************************************************************
    logic [ROW_ADDR_W-1:0] refresh_row;  // Internal refresh address.
    logic                  low_power;    // Any low-power state next.
    assign low_power = (next_state != lpsdc_pkg::LPSDC_ST_IDLE) &&
                       (next_state != lpsdc_pkg::LPSDC_ST_REFRESHING);

    // Row counter advances on each auto refresh, ignoring the address pins.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            refresh_row <= '0;
        end else if (refresh_go) begin
            refresh_row <= refresh_row + 1'b1;
        end
    end

    // Registered outputs.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_cmd             <= 4'h0;
            o_cmd_valid       <= 1'b0;
            o_state           <= 3'h0;
            o_bank_open       <= '0;
            o_bank_writing    <= '0;
            o_write_truncated <= 1'b0;
            o_refresh_row     <= '0;
            o_refresh_busy    <= 1'b0;
            o_core_clk_en     <= 1'b1;
            o_buffers_en      <= 1'b1;
            o_illegal         <= 1'b0;
        end else begin
            o_cmd             <= cmd;
            o_cmd_valid       <= bank_cmd && !nop_like;
            o_state           <= next_state;
            o_bank_open       <= bank_open;
            o_bank_writing    <= bank_writing;
            o_write_truncated <= |trunc_vec;
            o_refresh_row     <= refresh_row;
            o_refresh_busy    <= (next_state == lpsdc_pkg::LPSDC_ST_REFRESHING);
            o_core_clk_en     <= (next_state != lpsdc_pkg::LPSDC_ST_SELF_REFRESH) &&
                                 (next_state != lpsdc_pkg::LPSDC_ST_DEEP_SLEEP);
            o_buffers_en      <= !low_power;
            o_illegal         <= |illegal_vec;
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    // Refresh entry followed by a busy run of the stated length.
    sequence s_refresh_taken;
        refresh_go;
    endsequence
    property p_refresh_len;
        @(posedge i_mclk) disable iff (i_rst)
        s_refresh_taken |=> (state == lpsdc_pkg::LPSDC_ST_REFRESHING)
                            ##(REFRESH_CYCLES) (state == lpsdc_pkg::LPSDC_ST_IDLE);
    endproperty
    a_refresh_ends_idle: assert property (p_refresh_len)
        else $error("Refresh did not end in idle on time.");
    a_refresh_row_step: assert property (@(posedge i_mclk) disable iff (i_rst)
        refresh_go |=> refresh_row == $past(refresh_row) + 1'b1)
        else $error("Refresh row did not advance.");
    a_self_ref_entry: assert property (@(posedge i_mclk) disable iff (i_rst)
        (state == lpsdc_pkg::LPSDC_ST_IDLE && cke_fall && all_idle &&
         cmd == lpsdc_pkg::LPSDC_CMD_REFRESH) |=> state == lpsdc_pkg::LPSDC_ST_SELF_REFRESH)
        else $error("Self refresh not entered.");
    a_self_ref_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
        (state == lpsdc_pkg::LPSDC_ST_SELF_REFRESH && !pins.clk_en) |=>
        state == lpsdc_pkg::LPSDC_ST_SELF_REFRESH)
        else $error("Self refresh left with clock enable low.");
    a_clock_gated: assert property (@(posedge i_mclk) disable iff (i_rst)
        state == lpsdc_pkg::LPSDC_ST_SELF_REFRESH |-> !o_core_clk_en)
        else $error("Clock running in self refresh.");
    a_pd_kind: assert property (@(posedge i_mclk) disable iff (i_rst)
        (state == lpsdc_pkg::LPSDC_ST_IDLE && cke_fall && nop_like) |=>
        state == ($past(all_idle) ? lpsdc_pkg::LPSDC_ST_PRE_PD : lpsdc_pkg::LPSDC_ST_ACT_PD))
        else $error("Wrong power-down kind.");
    a_pd_buffers: assert property (@(posedge i_mclk) disable iff (i_rst)
        state == lpsdc_pkg::LPSDC_ST_PRE_PD |-> !o_buffers_en)
        else $error("Buffers on in power-down.");
    a_pd_exit: assert property (@(posedge i_mclk) disable iff (i_rst)
        (state == lpsdc_pkg::LPSDC_ST_ACT_PD && cke_rise && nop_like) |=>
        state == lpsdc_pkg::LPSDC_ST_IDLE)
        else $error("Power-down exit missed.");
    a_deep_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
        (state == lpsdc_pkg::LPSDC_ST_DEEP_SLEEP && !cke_prev && !pins.clk_en) |=>
        $stable(state))
        else $error("Deep sleep left with clock enable low.");
    a_write_trunc: assert property (@(posedge i_mclk) disable iff (i_rst)
        |trunc_vec |=> o_write_truncated && ((bank_writing & $past(trunc_vec)) == '0))
        else $error("Write burst not truncated.");

endmodule // lpsdc_core

`default_nettype wire

// *** sim/lpsdc_ctrl_model.sv ***
// Behavioural memory controller that drives the command pins of the command/state block.
`timescale 1ns/1ps
`default_nettype none
module lpsdc_ctrl_model (
    input  wire logic                   i_mclk,  // Memory clock, running whenever powered.
    output var  lpsdc_pkg::lpsdc_pins_s o_pins   // Command pins towards the memory.
);
    // ****************************************************************
    // Pin driving.
    // ****************************************************************
    // Clock enable starts high with the chip deselected.
    initial begin
        o_pins = 8'hF8;
    end

    // Drives one command just after a rising edge; pat is {cs_n, ras_n, cas_n, we_n}.
    task automatic put(input logic cke, input logic [3:0] pat, input logic [1:0] bank,
                       input logic all);
        @(posedge i_mclk);
        #1;
        o_pins = {cke, pat, bank, all};
    endtask

    // Deselects for n cycles; the ignored strobes carry fresh junk every cycle.
    task automatic idle(input int n, input logic cke);
        repeat (n) put(cke, {1'b1, 3'($urandom)}, 2'($urandom), 1'($urandom));
    endtask

    // Issues an auto refresh after precharge time and keeps quiet for the busy time.
    task automatic refresh();
        idle(lpsdc_pkg::PRECHARGE_CYCLES, 1'b1);
        put(1'b1, 4'b0001, 2'($urandom), 1'($urandom));
        idle(lpsdc_pkg::REFRESH_CYCLES + 4, 1'b1);
    endtask

    // Holds clock enable low; every other pin is random, since the memory ignores it.
    task automatic hold_low(input int n);
        repeat (n) put(1'b0, 4'($urandom), 2'($urandom), 1'($urandom));
    endtask

    // Leaves a low-power state with a no-operation, then waits out the exit time.
    task automatic wake();
        put(1'b1, 4'b0111, 2'($urandom), 1'($urandom));
        idle(6, 1'b1);
    endtask
endmodule  // lpsdc_ctrl_model
`default_nettype wire

// *** sim/tb_sdram_refresh_powerdown_cmd.sv ***
// Self-checking testbench of the command/state block with a controller model on its pins.
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_refresh_powerdown_cmd;
    logic                   i_mclk = 1'b0;  // System clock.
    logic                   i_rst  = 1'b1;  // Synchronous reset.
    lpsdc_pkg::lpsdc_pins_s pins;           // Pins from the controller model.
    logic [3:0]  o_cmd;
    logic        o_cmd_valid;
    logic [2:0]  o_state;
    logic [3:0]  o_bank_open;
    logic [3:0]  o_bank_writing;
    logic        o_write_truncated;
    logic [11:0] o_refresh_row;
    logic        o_refresh_busy;
    logic        o_core_clk_en;
    logic        o_buffers_en;
    logic        o_illegal;
    int          num_errors = 0;  // Mismatches seen.
    int          n_compared = 0;  // Comparisons made.
    int          n_trunc    = 0;  // Truncation pulses seen.
    int          n_illegal  = 0;  // Illegal-command pulses seen.
    logic [2:0]  exp_st[$];       // Expected state changes, oldest first.
    logic [3:0]  exp_cmd[$];      // Expected accepted commands, oldest first.
    logic [2:0]  last_st = 3'h0;  // Last state the watcher saw.
    logic [1:0]  b;               // Randomly chosen bank.
    logic [3:0]  lp_pat[3] = '{4'b0111, 4'b0001, 4'b0110};  // Entry command per low-power mode.
    logic [2:0]  lp_st[3]  = '{lpsdc_pkg::LPSDC_ST_PRE_PD, lpsdc_pkg::LPSDC_ST_SELF_REFRESH,
                               lpsdc_pkg::LPSDC_ST_DEEP_SLEEP};

    // The clock toggles every half period of 4 ns.
    always #4 i_mclk = ~i_mclk;

    lpsdc_ctrl_model u_ctrl (.i_mclk(i_mclk), .o_pins(pins));
    lpsdc_core dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_pins(pins), .o_cmd(o_cmd),
        .o_cmd_valid(o_cmd_valid), .o_state(o_state), .o_bank_open(o_bank_open),
        .o_bank_writing(o_bank_writing), .o_write_truncated(o_write_truncated),
        .o_refresh_row(o_refresh_row), .o_refresh_busy(o_refresh_busy),
        .o_core_clk_en(o_core_clk_en), .o_buffers_en(o_buffers_en), .o_illegal(o_illegal));

    // Counts one comparison and reports it at once if it failed.
    task automatic chk(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Notes the expected command, issues it, then lets it settle.
    task automatic bank_cmd(input logic [3:0] pat, input logic [1:0] bk, input logic all,
                            input logic [3:0] c);
        exp_cmd.push_back(c);
        u_ctrl.put(1'b1, pat, bk, all);
        u_ctrl.idle(6, 1'b1);
    endtask

    // Runs one auto refresh and checks the row counter and the idle banks after it.
    task automatic do_refresh();
        logic [11:0] row;
        row = o_refresh_row;
        exp_st.push_back(lpsdc_pkg::LPSDC_ST_REFRESHING);
        exp_st.push_back(lpsdc_pkg::LPSDC_ST_IDLE);
        exp_cmd.push_back(lpsdc_pkg::LPSDC_CMD_REFRESH);
        u_ctrl.refresh();
        chk(o_refresh_row === row + 12'h1 && o_bank_open === 4'h0, "refresh");
    endtask

    // Watcher: each state change and accepted command takes the oldest note.
    always @(posedge i_mclk) begin
        if (!i_rst && o_state !== last_st) begin
            chk(exp_st.size() != 0 && o_state === exp_st.pop_front(), "state");
            chk(o_refresh_busy === (o_state === 3'(lpsdc_pkg::LPSDC_ST_REFRESHING)), "busy");
            last_st = o_state;
        end
        if (!i_rst && o_cmd_valid === 1'b1) begin
            chk(exp_cmd.size() != 0 && o_cmd === exp_cmd.pop_front(), "command");
        end
        if (!i_rst && o_write_truncated === 1'b1) begin
            n_trunc++;
        end
        if (!i_rst && o_illegal === 1'b1) begin
            n_illegal++;
        end
    end

    // Main sequence: bank commands, active power-down, then each mode from all banks idle.
    initial begin
        void'($urandom(32'h314d1980));
        repeat (12) @(posedge i_mclk);
        #1 i_rst = 1'b0;
        chk(o_state === 3'h0 && o_core_clk_en === 1'b1 && o_buffers_en === 1'b1, "reset");
        u_ctrl.idle(4, 1'b1);
        b = 2'($urandom);
        bank_cmd(4'b0011, b, 1'b0, lpsdc_pkg::LPSDC_CMD_ACTIVE);
        bank_cmd(4'b0011, b + 2'h1, 1'b0, lpsdc_pkg::LPSDC_CMD_ACTIVE);
        bank_cmd(4'b0100, b, 1'b0, lpsdc_pkg::LPSDC_CMD_WRITE);
        chk(o_bank_writing[b] === 1'b1 && o_bank_open[b] === 1'b1, "write");
        bank_cmd(4'b0101, b, 1'b0, lpsdc_pkg::LPSDC_CMD_READ);
        bank_cmd(4'b0100, b + 2'h1, 1'b0, lpsdc_pkg::LPSDC_CMD_WRITE);
        bank_cmd(4'b0010, b + 2'h1, 1'b0, lpsdc_pkg::LPSDC_CMD_PRECHARGE);
        chk(n_trunc == 2 && o_bank_writing === 4'h0 && n_illegal == 0, "truncate");
        bank_cmd(4'b0101, b + 2'h2, 1'b0, lpsdc_pkg::LPSDC_CMD_READ);
        chk(n_illegal == 1, "illegal");
        exp_st.push_back(lpsdc_pkg::LPSDC_ST_ACT_PD);
        exp_st.push_back(lpsdc_pkg::LPSDC_ST_IDLE);
        u_ctrl.put(1'b0, 4'b0111, 2'h0, 1'b0);
        u_ctrl.hold_low(8);
        chk(o_state === 3'(lpsdc_pkg::LPSDC_ST_ACT_PD) && o_buffers_en === 1'b0, "act pd");
        u_ctrl.wake();
        bank_cmd(4'b0010, 2'h0, 1'b1, lpsdc_pkg::LPSDC_CMD_PRECHARGE);
        for (int k = 0; k < 3; k++) begin
            exp_st.push_back(lp_st[k]);
            exp_st.push_back(lpsdc_pkg::LPSDC_ST_IDLE);
            u_ctrl.put(1'b0, lp_pat[k], 2'h0, 1'b0);
            u_ctrl.hold_low(8);
            chk(o_state === lp_st[k] && o_buffers_en === 1'b0, "low power");
            chk(o_core_clk_en === 1'(k == 0), "clock gate");
            u_ctrl.wake();
            if (k == 2) begin
                u_ctrl.idle(25000, 1'b1);
                bank_cmd(4'b0010, 2'h0, 1'b1, lpsdc_pkg::LPSDC_CMD_PRECHARGE);
                do_refresh();
            end
            do_refresh();
        end
        bank_cmd(4'b0000, 2'h0, 1'b0, lpsdc_pkg::LPSDC_CMD_MODE_SET);
        chk(exp_st.size() == 0 && exp_cmd.size() == 0, "pending");
        report_and_stop();
    end

    // Watchdog sized well above the roughly 25200 cycles the sequence needs.
    initial begin
        repeat (40000) @(posedge i_mclk);
        num_errors++;
        report_and_stop();
    end
endmodule  // tb_sdram_refresh_powerdown_cmd
`default_nettype wire
